// ### hw/ckirq_top.sv
// clock manager interrupt status block: raw, masked, clear and status registers
// Operation
// - latch oscillator ready and switch-done flags
// - pll ready flag at bit seven
// - failure and failure-end flags bits twelve-fifteen
// - five ready flags set after reset
// - low-voltage irq flag only when enabled
// - reset-level flag sets, never interrupts
// - reset-level flag mirrored, cleared by write-one
// - command error flag at bit eighteen
// - raw status reads flags, ignores writes
// - masked status is raw and enable
// - masked reads, bit seventeen zero, writes ignored
// - write one clears flag, zero ignored
// - only implemented clear bits take effect
// - status register reset value and layout
// - mask register read back, one enables
// - disabled source select in the three peripheral fields kept, error flagged
// - raw status at 0x34, resets to 0x1f
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ckirq_top
    import ckirq_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output var logic [31:0] o_rdata,
    // hardware events (pulses or levels from clock logic)
    input wire logic [4:0] i_osc_ready_evt,
    input wire logic i_pll_ready_evt,
    input wire logic [3:0] i_osc_fail_evt,
    input wire logic i_low_voltage_irq_lvl,
    input wire logic i_low_voltage_reset_lvl,
    input wire logic [3:0] i_src_enabled,
    input wire logic [7:0] i_reset_cause,
    input wire logic [10:0] i_misc_status,
    // outputs
    output var logic [14:0] o_periph_sel,
    output var logic o_low_voltage_irq_enable,
    output var logic o_low_voltage_reset_enable,
    output var logic o_irq
);
    // ************************************************************
    // input synchronisers (voltage detector levels are asynchronous)
    // ************************************************************
    logic [1:0] lv_meta_r;  // first stage, read only by second
    logic [1:0] lv_sync_r;  // usable levels
    // two flops per level: the detector output is not timed to this clock
    // and the first stage may go metastable, so only the second one is read
    always_ff @(posedge i_clk_sys) begin
        lv_meta_r <= {i_low_voltage_reset_lvl, i_low_voltage_irq_lvl};
        lv_sync_r <= lv_meta_r;
    end

    // ************************************************************
    // bus decode
    // ************************************************************
    // strobes decode combinationally; the slave never holds the master off
    logic wr_mask;   // mask write
    logic wr_clear;  // clear write
    logic wr_mode;   // peripheral select write
    logic wr_lvctl;  // low-voltage control write
    logic wr_stat;   // status write (reset cause clear)
    assign wr_mask = i_wr && (i_addr == CKIRQ_OFS_MASK);
    assign wr_clear = i_wr && (i_addr == CKIRQ_OFS_CLEAR);
    assign wr_mode = i_wr && (i_addr == CKIRQ_OFS_MODE);
    assign wr_lvctl = i_wr && (i_addr == CKIRQ_OFS_LVCTL);
    assign wr_stat = i_wr && (i_addr == CKIRQ_OFS_STATUS);

    // ************************************************************
    // mask and low-voltage control
    // ************************************************************
    logic [31:0] mask_r;   // interrupt enables
    logic [1:0] lvctl_r;   // {irq enable, reset enable}
    // enables; reserved bits and bit 17 stay zero so they can never interrupt
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            mask_r <= CKIRQ_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= i_wdata & CKIRQ_IRQ_BITS;
        end
    end
    // low-voltage enables; the reset enable comes up on so a brown-out
    // before software has run still resets the chip
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            lvctl_r <= CKIRQ_LVCTL_RST;
        end else if (wr_lvctl) begin
            lvctl_r <= i_wdata[1:0];
        end
    end
    // enables leave as plain levels for the voltage detector
    assign o_low_voltage_irq_enable = lvctl_r[1];
    assign o_low_voltage_reset_enable = lvctl_r[0];

    // ************************************************************
    // peripheral clock selects with command error check
    // ************************************************************
    // three 3-bit fields at 4,8,12 plus system select 2:0; value 0..3
    // names a source, others disconnect; always legal in the fields, system select refuses 5..7
    // true when a source code names an oscillator that is stopped
    function automatic logic sel_bad(input logic [2:0] s, input logic [3:0] en);
        sel_bad = (s[2] == 1'b0) && !en[s[1:0]];
    endfunction : sel_bad
    logic [14:0] mode_r;  // peripheral selects
    logic cmd_err_evt;    // illegal select attempted
    logic [14:0] mode_nxt;  // next selects
    // one write may carry good and bad fields at once: each bad field keeps
    // its old code and only raises the error, the good ones still update
    always_comb begin
        mode_nxt = mode_r;
        cmd_err_evt = 1'b0;
        if (wr_mode) begin
            for (int f = 1; f < 4; f++) begin
                if (sel_bad(i_wdata[f*4 +: 3], i_src_enabled)) begin
                    cmd_err_evt = 1'b1;
                end else begin
                    mode_nxt[f*4 +: 3] = i_wdata[f*4 +: 3];
                end
            end
            // system select: prohibited codes leave it unchanged
            if (i_wdata[2:0] <= 3'h4) begin
                mode_nxt[2:0] = i_wdata[2:0];
            end
        end
    end
    // select register; an error blocks a field, never the whole write
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            mode_r <= CKIRQ_MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end
    assign o_periph_sel = mode_r;

    // ************************************************************
    // raw flags
    // ************************************************************
    logic [31:0] set_vec;  // event vector
    logic [31:0] clr_vec;  // write-one clears
    logic [31:0] raw;      // raw flags
    // event vector laid out as the raw register; the reset-level bit
    // ignores the reset enable on purpose
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[4:0] = i_osc_ready_evt;
        set_vec[CKIRQ_B_PLL] = i_pll_ready_evt;
        set_vec[15:12] = i_osc_fail_evt;
        set_vec[CKIRQ_B_LVIRQ] = lv_sync_r[0] & lvctl_r[1];
        set_vec[CKIRQ_B_LVRS] = lv_sync_r[1];
        set_vec[CKIRQ_B_COMMAND_ERROR_FLAG] = cmd_err_evt;
    end
    // reserved clear bits are dropped so a careless all-ones write is harmless
    assign clr_vec = wr_clear ? (i_wdata & CKIRQ_RAW_BITS) : 32'h0000_0000;
    // one 32-bit bank keeps the bit map equal to the register; i_impl prunes
    ckirq_flag_bank #(
        .W(32)
    ) u_flags (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_set(set_vec),
        .i_clr(clr_vec),
        .i_impl(CKIRQ_RAW_BITS),
        .o_flags(raw)
    );

    // ************************************************************
    // masked view and interrupt
    // ************************************************************
    // bit 17 has no enable, so the reset-level flag can never interrupt
    logic [31:0] masked;  // masked status, bit 17 never included
    assign masked = raw & mask_r & CKIRQ_IRQ_BITS;
    // registered so decode glitches never reach the core, at one cycle of delay
    logic irq_r;  // registered level interrupt
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |masked;
        end
    end
    assign o_irq = irq_r;

    // ************************************************************
    // reset cause bits, caught after reset release, write-one clears
    // ************************************************************
    logic [7:0] cause_r;  // reset-cause flags
    logic cause_cap_r;    // capture done
    // limitation: a clear written in the capture cycle is lost; software
    // reads the cause first and clears it afterwards anyway
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cause_r <= 8'h00;
            cause_cap_r <= 1'b0;
        end else if (!cause_cap_r) begin
            cause_r <= i_reset_cause;  // strap caught after release
            cause_cap_r <= 1'b1;
        end else if (wr_stat) begin
            cause_r <= cause_r & ~i_wdata[31:24];
        end
    end

    // ************************************************************
    // status register assembly
    // ************************************************************
    // misc: [0]=fast wake,[4:1]=idle bits 8..11,[5]=idle stop,[10:6] spare
    logic [31:0] status;  // assembled status word
    // monitor enables live outside this block, so 23:20 show their reset value
    always_comb begin
        status = raw & CKIRQ_RAW_BITS;  // same bit 17
        status[5] = i_misc_status[0];
        status[11:8] = i_misc_status[4:1];
        status[19] = i_misc_status[5];
        status[23:20] = CKIRQ_MON_RST;
        status[31:24] = cause_r;
    end

    // ************************************************************
    // read mux (data one cycle after strobe)
    // ************************************************************
    logic [31:0] rdata_r;  // read data register
    // data stand for one cycle and are zero otherwise; writes to the raw and
    // masked views reach no process, so they change nothing
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                CKIRQ_OFS_MODE: rdata_r <= {17'h0, mode_r};
                CKIRQ_OFS_MASK: rdata_r <= mask_r;
                CKIRQ_OFS_RAW: rdata_r <= raw;
                CKIRQ_OFS_MASKED: rdata_r <= masked;
                CKIRQ_OFS_STATUS: rdata_r <= status;
                CKIRQ_OFS_LVCTL: rdata_r <= {30'h0, lvctl_r};
                default: rdata_r <= 32'h0000_0000;         // clear reg and unmapped
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end
    assign o_rdata = rdata_r;

    // ************************************************************
    // assertions
    // ************************************************************
    // guards sit beside the logic so a change above meets its check at once
    a_raw_reset_val: assert property (@(posedge i_clk_sys)
        !i_reset_n |=> raw == CKIRQ_RAW_RST) else $error("raw reset value wrong");
    a_set_beats_clr: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (set_vec[CKIRQ_B_PLL] && clr_vec[CKIRQ_B_PLL]) |=> raw[CKIRQ_B_PLL])
        else $error("event lost to clear");
    a_clear_works: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (clr_vec[3] && !set_vec[3]) |=> !raw[3]) else $error("clear ignored");
    a_lvirq_gated: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!$past(raw[16]) && raw[16]) |-> $past(lvctl_r[1])) else $error("lv irq set while off");
    a_lvrs_no_irq: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (raw == 32'h0002_0000) |=> !o_irq) else $error("reset-level flag raised irq");
    a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (|masked) |=> o_irq) else $error("irq missing");
    a_masked_rd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_rd && i_addr == CKIRQ_OFS_MASKED) |=> o_rdata[17] == 1'b0) else $error("bit 17 set");
    a_command_error_flag_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        cmd_err_evt |=> raw[CKIRQ_B_COMMAND_ERROR_FLAG]) else $error("command error not latched");
    a_sel_kept: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_mode && sel_bad(i_wdata[6:4], i_src_enabled))
        |=> mode_r[6:4] == $past(mode_r[6:4])) else $error("refused select changed");
    a_sel_taken: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_mode && !sel_bad(i_wdata[6:4], i_src_enabled))
        |=> mode_r[6:4] == $past(i_wdata[6:4])) else $error("legal select not taken");
    a_raw_nowrite: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_wr && i_addr == CKIRQ_OFS_RAW && set_vec == 32'h0) |=> $stable(raw))
        else $error("raw write changed flags");
    a_lvrs_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (raw[CKIRQ_B_LVRS] && !clr_vec[CKIRQ_B_LVRS]) |=> raw[CKIRQ_B_LVRS])
        else $error("reset-level flag dropped");
    a_irq_drops: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !(|masked) |=> !o_irq) else $error("irq without masked bit");
    a_irq_rst: assert property (@(posedge i_clk_sys)
        !i_reset_n |=> !o_irq) else $error("irq high after reset");
    a_clear_rd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_rd && i_addr == CKIRQ_OFS_CLEAR) |=> o_rdata == 32'h0000_0000)
        else $error("clear register read nonzero");
    a_cause_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_stat && cause_cap_r) |=> (cause_r & $past(i_wdata[31:24])) == 8'h00)
        else $error("reset cause not cleared");
    c_clear_after_reset: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        wr_clear && clr_vec[4:0] == 5'h1f);
    c_irq_raised: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) $rose(o_irq));
    c_cmd_err: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) cmd_err_evt);
    c_set_and_clear: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        set_vec[CKIRQ_B_PLL] && clr_vec[CKIRQ_B_PLL]);
    c_lvrs_set: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(raw[CKIRQ_B_LVRS]));
endmodule : ckirq_top
`default_nettype wire

// ### hw/ckirq_pkg.sv
// package of offsets, bit positions and reset values for the clock manager interrupt status block
package ckirq_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] CKIRQ_OFS_MODE = 8'h2c;        // clock mode control (peripheral selects)
    localparam logic [7:0] CKIRQ_OFS_MASK = 8'h30;        // clock_irq_enable_mask
    localparam logic [7:0] CKIRQ_OFS_RAW = 8'h34;         // clock_irq_raw_status
    localparam logic [7:0] CKIRQ_OFS_MASKED = 8'h38;      // clock_irq_masked_status
    localparam logic [7:0] CKIRQ_OFS_CLEAR = 8'h3c;       // clock_irq_clear
    localparam logic [7:0] CKIRQ_OFS_STATUS = 8'h40;      // clock_manager_status
    localparam logic [7:0] CKIRQ_OFS_LVCTL = 8'h4c;       // low-voltage enables
    // ************************************************************
    // flag bit positions
    // ************************************************************
    localparam int CKIRQ_B_COMMAND_ERROR_FLAG = 18;                   // command error
    localparam int CKIRQ_B_LVRS = 17;                     // reset-level flag
    localparam int CKIRQ_B_LVIRQ = 16;                    // low-voltage irq flag
    localparam int CKIRQ_B_PLL = 7;                       // pll ready
    // ************************************************************
    // masks and reset values
    // ************************************************************
    localparam logic [31:0] CKIRQ_RAW_BITS = 32'h0007_f09f;   // implemented raw bits
    localparam logic [31:0] CKIRQ_IRQ_BITS = 32'h0005_f09f;   // bits that may interrupt
    localparam logic [31:0] CKIRQ_RAW_RST = 32'h0000_001f;    // raw flags after reset
    localparam logic [31:0] CKIRQ_MASK_RST = 32'h0000_0000;   // mask after reset
    localparam logic [3:0] CKIRQ_MON_RST = 4'ha;              // monitor enables 23..20
    localparam logic [14:0] CKIRQ_MODE_RST = 15'h0310;        // peripheral select reset
    localparam logic [1:0] CKIRQ_LVCTL_RST = 2'h1;            // irq en=0, reset en=1
endpackage : ckirq_pkg

// ### hw/ckirq_flag_bank.sv
// sticky flag bank: hardware sets, write-one clears, set beats clear
`timescale 1ns/10ps
`default_nettype none
module ckirq_flag_bank
    import ckirq_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // set and clear
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    input wire logic [W-1:0] i_impl,
    // flags
    output var logic [W-1:0] o_flags
);
    logic [W-1:0] flags_r;  // held flags
    // ************************************************************
    // flag update
    // ************************************************************
    // set is or-ed in after the clear so a same-cycle event survives
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            flags_r <= CKIRQ_RAW_RST[W-1:0];
        end else begin
            flags_r <= ((flags_r & ~i_clr) | i_set) & i_impl;
        end
    end
    assign o_flags = flags_r;
endmodule : ckirq_flag_bank
`default_nettype wire

// ### tb/tb_ckirq_top.sv
// self-checking testbench for the clock manager interrupt status block
`timescale 1ns/10ps
`default_nettype none
module tb_ckirq_top;
    import ckirq_pkg::*;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [4:0] i_osc_ready_evt = 5'h00;
    logic i_pll_ready_evt = 1'b0;
    logic [3:0] i_osc_fail_evt = 4'h0;
    logic i_lv_irq = 1'b0;  // low-voltage irq level, synced inside
    logic i_lv_rst = 1'b0;  // low-voltage reset level, synced inside
    logic [3:0] i_src_enabled = 4'hf;
    logic [7:0] i_reset_cause = 8'h10;
    logic [10:0] i_misc_status = 11'h021;  // lands on status bits 5 and 19
    logic [31:0] o_rdata;
    logic [14:0] o_periph_sel;
    logic o_lv_irq_en;
    logic o_lv_rst_en;
    logic o_irq;
    logic [31:0] d;
    int fails = 0;
    int n_tests = 0;
    ckirq_top ckirq_top_i (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_osc_ready_evt(i_osc_ready_evt), .i_pll_ready_evt(i_pll_ready_evt),
        .i_osc_fail_evt(i_osc_fail_evt), .i_low_voltage_irq_lvl(i_lv_irq),
        .i_low_voltage_reset_lvl(i_lv_rst), .i_src_enabled(i_src_enabled),
        .i_reset_cause(i_reset_cause), .i_misc_status(i_misc_status),
        .o_periph_sel(o_periph_sel), .o_low_voltage_irq_enable(o_lv_irq_en),
        .o_low_voltage_reset_enable(o_lv_rst_en), .o_irq(o_irq)
    );
    // 200 MHz system clock
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // ************************************************************
    // bus tasks and compares
    // ************************************************************
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk32
    task chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1
    // one-cycle write strobe, no wait state
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a, d);
        chk32(name, exp, d);
    endtask : rchk
    // the level inputs pass a synchroniser, so poll with a bound
    task wait_raw(input int b);
        int k;
        for (k = 0; k < 20; k++) begin
            rd(CKIRQ_OFS_RAW, d);
            if (d[b] === 1'b1) break;
        end
        if (k == 20) begin
            fails++;
            $display("Error raw bit %0d never set", b);
            final_report();
        end
    endtask : wait_raw
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        // reset values of the raw, masked, mask, clear and status reads, plus the reset enable
        rchk("raw rst", CKIRQ_OFS_RAW, 32'h0000_001f);
        rchk("masked rst", CKIRQ_OFS_MASKED, 32'h0000_0000);
        rchk("mask rst", CKIRQ_OFS_MASK, 32'h0000_0000);
        rchk("clear rd", CKIRQ_OFS_CLEAR, 32'h0000_0000);
        rchk("status rst", CKIRQ_OFS_STATUS, 32'h10a8_003f);
        rchk("unmapped", 8'h50, 32'h0000_0000);
        chk1("irq rst", 1'b0, o_irq);
        chk1("lv rst en", 1'b1, o_lv_rst_en);
        // read-only views ignore writes, zero clear ignored
        wr(CKIRQ_OFS_RAW, 32'hffff_ffff);
        wr(CKIRQ_OFS_MASKED, 32'hffff_ffff);
        wr(CKIRQ_OFS_CLEAR, 32'h0000_0000);
        rchk("raw wr", CKIRQ_OFS_RAW, 32'h0000_001f);
        rchk("masked wr", CKIRQ_OFS_MASKED, 32'h0000_0000);
        // enable all sources, then clear the set-at-reset flags
        wr(CKIRQ_OFS_MASK, 32'hffff_ffff);
        rchk("mask rb", CKIRQ_OFS_MASK, CKIRQ_IRQ_BITS);
        rchk("masked on", CKIRQ_OFS_MASKED, 32'h0000_001f);
        chk1("irq on", 1'b1, o_irq);
        wr(CKIRQ_OFS_CLEAR, 32'h0000_001f);
        rchk("raw clr", CKIRQ_OFS_RAW, 32'h0000_0000);
        chk1("irq off", 1'b0, o_irq);
        // every pulse event source for one cycle
        @(posedge i_clk_sys);
        i_osc_ready_evt <= 5'h1f;
        i_pll_ready_evt <= 1'b1;
        i_osc_fail_evt <= 4'hf;
        @(posedge i_clk_sys);
        i_osc_ready_evt <= 5'h00;
        i_pll_ready_evt <= 1'b0;
        i_osc_fail_evt <= 4'h0;
        rchk("raw evt", CKIRQ_OFS_RAW, 32'h0000_f09f);
        rchk("masked evt", CKIRQ_OFS_MASKED, 32'h0000_f09f);
        wr(CKIRQ_OFS_CLEAR, 32'hfff8_0f60);
        rchk("raw rsvd clr", CKIRQ_OFS_RAW, 32'h0000_f09f);
        wr(CKIRQ_OFS_CLEAR, 32'h0000_f000);
        rchk("raw part clr", CKIRQ_OFS_RAW, 32'h0000_009f);
        wr(CKIRQ_OFS_CLEAR, 32'h0000_009f);
        // event and clear of the same flag in one cycle: event wins
        @(posedge i_clk_sys);
        i_pll_ready_evt <= 1'b1;
        i_addr <= CKIRQ_OFS_CLEAR;
        i_wdata <= 32'h0000_0080;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_pll_ready_evt <= 1'b0;
        i_wr <= 1'b0;
        rchk("set wins", CKIRQ_OFS_RAW, 32'h0000_0080);
        wr(CKIRQ_OFS_CLEAR, 32'h0000_0080);
        // low-voltage irq flag needs its enable
        i_lv_irq <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        rchk("lv irq off", CKIRQ_OFS_RAW, 32'h0000_0000);
        wr(CKIRQ_OFS_LVCTL, 32'h0000_0003);
        wait_raw(CKIRQ_B_LVIRQ);
        chk1("lv irq en", 1'b1, o_lv_irq_en);
        i_lv_irq <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        wr(CKIRQ_OFS_CLEAR, 32'h0001_0000);
        rchk("lv irq clr", CKIRQ_OFS_RAW, 32'h0000_0000);
        // reset-level flag: sets with reset enable off, never interrupts
        wr(CKIRQ_OFS_LVCTL, 32'h0000_0002);
        i_lv_rst <= 1'b1;
        wait_raw(CKIRQ_B_LVRS);
        chk1("lv rst en off", 1'b0, o_lv_rst_en);
        i_lv_rst <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        rchk("lvrs sticky", CKIRQ_OFS_RAW, 32'h0002_0000);
        rchk("lvrs masked", CKIRQ_OFS_MASKED, 32'h0000_0000);
        chk1("lvrs no irq", 1'b0, o_irq);
        rd(CKIRQ_OFS_STATUS, d);
        chk1("status lvrs", 1'b1, d[17]);
        wr(CKIRQ_OFS_CLEAR, 32'h0002_0000);
        rchk("lvrs clr", CKIRQ_OFS_RAW, 32'h0000_0000);
        // select of a disabled source is refused and flagged
        i_src_enabled <= 4'h1;
        wr(CKIRQ_OFS_MODE, 32'h0000_0320);
        rchk("cmd err", CKIRQ_OFS_RAW, 32'h0004_0000);
        chk32("sel kept", 32'h0000_0310, {17'h0, o_periph_sel});
        chk1("cmd irq", 1'b1, o_irq);
        wr(CKIRQ_OFS_MODE, 32'h0000_0300);
        wr(CKIRQ_OFS_CLEAR, 32'h0004_0000);
        rchk("cmd clr", CKIRQ_OFS_RAW, 32'h0000_0000);
        chk32("sel new", 32'h0000_0300, {17'h0, o_periph_sel});
        // reset-cause bits clear on write of one
        wr(CKIRQ_OFS_STATUS, 32'hff00_0000);
        rd(CKIRQ_OFS_STATUS, d);
        chk32("cause clr", 32'h0000_0000, d & 32'hff00_0000);
        final_report();
    end
endmodule : tb_ckirq_top
`default_nettype wire
